/* File: src/lpdac_cfg.svh */
`ifndef LPDAC_CFG_SVH
`define LPDAC_CFG_SVH

// Byte addresses of the registers.
`define LPDAC_OFS_REFBUF 16'h2050
`define LPDAC_OFS_DATA 16'h2120
`define LPDAC_OFS_SWITCH 16'h2124
`define LPDAC_OFS_CONFIG 16'h2128
`define LPDAC_OFS_CMMUX 16'h235C
`define LPDAC_OFS_FRONTEND 16'h2000

// Reset values.
`define LPDAC_RST_REFBUF 2'h0
`define LPDAC_RST_DATA 18'h00000
`define LPDAC_RST_SWITCH 6'h00
`define LPDAC_RST_CONFIG 7'h02
`define LPDAC_RST_WORD 32'h00000000

// Configuration field positions and width.
`define LPDAC_CFG_WE 0
`define LPDAC_CFG_PWD 1
`define LPDAC_CFG_SRC 6
`define LPDAC_CFG_W 7

// Data, switch, reference buffer, common-mode and front-end field layout.
`define LPDAC_BIAS_W 12
`define LPDAC_ZERO_W 6
`define LPDAC_DATA_W 18
`define LPDAC_SW_W 6
`define LPDAC_REFBUF_W 2
`define LPDAC_CM_SETUP_BIT 3
`define LPDAC_HS_BUF_BIT 21

// Switch patterns, bit n closes switch n.
`define LPDAC_SW_OPEN 5'h00
`define LPDAC_SW_NORMAL 5'h0C
`define LPDAC_SW_DIAG 5'h11

// Bus responses.
`define LPDAC_RESP_OKAY 2'h0
`define LPDAC_RESP_SLVERR 2'h2

`endif

/* File: src/lpdac_pkg.sv */
`include "lpdac_cfg.svh"

package lpdac_pkg;

  // One-hot register selector from the address decoder.
  typedef enum logic [6:0] {
    LPDAC_SEL_NONE = 7'h01,
    LPDAC_SEL_REFBUF = 7'h02,
    LPDAC_SEL_DATA = 7'h04,
    LPDAC_SEL_SWITCH = 7'h08,
    LPDAC_SEL_CONFIG = 7'h10,
    LPDAC_SEL_CMMUX = 7'h20,
    LPDAC_SEL_FRONTEND = 7'h40
  } lpdac_sel_type;

  // The two codes, packed as they sit in the data register.
  typedef struct packed {
    logic [`LPDAC_ZERO_W-1:0] zero;
    logic [`LPDAC_BIAS_W-1:0] bias;
  } lpdac_codes_type;

  // Configuration bits 6 down to 1, in register order.
  typedef struct packed {
    logic from_wavegen;
    logic diag_mode;
    logic zero_from_12b;
    logic bias_from_6b;
    logic ref_supply;
    logic power_down;
  } lpdac_route_type;

  // Switch control register contents.
  typedef struct packed {
    logic override;
    logic [4:0] closed;
  } lpdac_switch_type;

endpackage : lpdac_pkg

/* File: src/lpdac_switch_sel.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lpdac_cfg.svh"

module lpdac_switch_sel (
  input wire lpdac_pkg::lpdac_route_type route, // Decoded configuration.
  input wire lpdac_pkg::lpdac_switch_type sw, // Switch register.
  output logic [4:0] closed // Bit n high closes switch n.
);
  import lpdac_pkg::*;

  // Power-down wins over everything so no output is ever left connected.
  always_comb begin
    if (route.power_down) begin
      closed = `LPDAC_SW_OPEN;
    end else if (sw.override) begin
      closed = sw.closed;
    end else if (route.diag_mode) begin
      closed = `LPDAC_SW_DIAG;
    end else begin
      closed = `LPDAC_SW_NORMAL;
    end
  end

endmodule : lpdac_switch_sel

`default_nettype wire

/* File: src/lpdac_code_mux.sv */
`timescale 1ns/10ps
`default_nettype none

module lpdac_code_mux (
  input wire lpdac_pkg::lpdac_route_type route, // Decoded configuration.
  input wire lpdac_pkg::lpdac_codes_type data_codes, // From data register.
  input wire lpdac_pkg::lpdac_codes_type wave_codes, // From wave generator.
  output lpdac_pkg::lpdac_codes_type codes, // Codes fed to the strings.
  output lpdac_pkg::lpdac_codes_type node_codes // Codes seen on the nodes.
);
  import lpdac_pkg::*;

  // Pick the code source.
  always_comb begin
    codes = route.from_wavegen ? wave_codes : data_codes;
  end

  // One 6-bit step equals 64 steps of the 12-bit string, so a swapped
  // node is shown in the other output's scale by a 6-bit shift.
  always_comb begin
    node_codes.bias = route.bias_from_6b ? {codes.zero, 6'h00}
                                         : codes.bias;
    node_codes.zero = route.zero_from_12b ? codes.bias[11:6]
                                          : codes.zero;
  end

endmodule : lpdac_code_mux

`default_nettype wire

/* File: src/lpdac_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lpdac_cfg.svh"

module lpdac_top #(
  parameter int ADDR_W = 16 // Byte address width of the slave.
) (
  input wire logic clk_sys, // System clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte enables.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire lpdac_pkg::lpdac_codes_type wave_codes, // Wave generator codes.
  output lpdac_pkg::lpdac_codes_type dac_codes, // Codes to the strings.
  output lpdac_pkg::lpdac_codes_type node_codes, // Codes on the nodes.
  output lpdac_pkg::lpdac_route_type route, // Source, mux, ref, power.
  output logic [4:0] switch_closed, // Output switches, high closed.
  output logic [1:0] ref_buf_off, // Buffer and reference power-down.
  output logic cm_setup_en, // Common-mode setup enable.
  output logic hs_dac_buf_en // Fast DAC dc buffer enable.
);
  import lpdac_pkg::*;

  // The decoder compares 16-bit offsets, so the address must hold them.
  if (ADDR_W < 16) begin : g_addr_check
    $error("ADDR_W must be at least 16");
  end

  logic aw_hold, w_hold;
  logic next_aw_hold, next_w_hold, next_bvalid, next_rvalid;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write, do_read;
  lpdac_sel_type wr_sel, rd_sel, rd_sel_q;
  logic [31:0] wr_word;
  logic [`LPDAC_REFBUF_W-1:0] refbuf;
  lpdac_codes_type data;
  lpdac_switch_type sw;
  logic [`LPDAC_CFG_W-1:0] cfg;
  logic [31:0] cmmux, frontend;
  lpdac_route_type cfg_route;
  lpdac_codes_type mux_codes, mux_nodes;
  logic [4:0] mux_closed;

  // Address decode shared by the read and the write path.
  function automatic lpdac_sel_type decode(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] w;
    w = a & ~{{(ADDR_W-2){1'b0}}, 2'h3};
    if (w == ADDR_W'(`LPDAC_OFS_REFBUF)) return LPDAC_SEL_REFBUF;
    if (w == ADDR_W'(`LPDAC_OFS_DATA)) return LPDAC_SEL_DATA;
    if (w == ADDR_W'(`LPDAC_OFS_SWITCH)) return LPDAC_SEL_SWITCH;
    if (w == ADDR_W'(`LPDAC_OFS_CONFIG)) return LPDAC_SEL_CONFIG;
    if (w == ADDR_W'(`LPDAC_OFS_CMMUX)) return LPDAC_SEL_CMMUX;
    if (w == ADDR_W'(`LPDAC_OFS_FRONTEND)) return LPDAC_SEL_FRONTEND;
    return LPDAC_SEL_NONE;
  endfunction : decode

  // Read view of every register; bits not stored read zero.
  function automatic logic [31:0] view(input lpdac_sel_type s);
    logic [31:0] v;
    v = `LPDAC_RST_WORD;
    unique case (s)
      LPDAC_SEL_REFBUF: v = {30'h0, refbuf};
      LPDAC_SEL_DATA: v = {14'h0, data};
      LPDAC_SEL_SWITCH: v = {26'h0, sw};
      LPDAC_SEL_CONFIG: v = {25'h0, cfg};
      LPDAC_SEL_CMMUX: v = cmmux;
      LPDAC_SEL_FRONTEND: v = frontend;
      LPDAC_SEL_NONE: v = `LPDAC_RST_WORD;
    endcase
    return v;
  endfunction : view

  // Write channel flow: address and data are taken in either order,
  // and new ones wait until the response has been accepted.
  always_comb begin
    do_write = aw_hold && w_hold && !s_axi_bvalid;
    next_aw_hold = (aw_hold || (s_axi_awvalid && s_axi_awready))
                   && !do_write;
    next_w_hold = (w_hold || (s_axi_wvalid && s_axi_wready)) && !do_write;
    next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);
    do_read = s_axi_arvalid && s_axi_arready;
    next_rvalid = do_read || (s_axi_rvalid && !s_axi_rready);
    wr_sel = do_write ? decode(aw_addr) : LPDAC_SEL_NONE;
    rd_sel = decode(s_axi_araddr);
  end

  // Byte enables merge new bytes into the current register view.
  always_comb begin
    wr_word = view(wr_sel);
    for (int i = 0; i < 4; i++) begin
      if (w_strb[i]) begin
        wr_word[8*i +: 8] = w_data[8*i +: 8];
      end
    end
  end

  // Write handshake registers.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LPDAC_RESP_OKAY;
    end else begin
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      s_axi_awready <= !next_aw_hold && !next_bvalid;
      s_axi_wready <= !next_w_hold && !next_bvalid;
      s_axi_bvalid <= next_bvalid;
      if (do_write) begin
        s_axi_bresp <= (wr_sel == LPDAC_SEL_NONE) ? `LPDAC_RESP_SLVERR
                                                  : `LPDAC_RESP_OKAY;
      end
    end
  end

  // Captured write address and data.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      aw_addr <= '0;
      w_data <= `LPDAC_RST_WORD;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // Read channel; data is sampled at the address handshake.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `LPDAC_RST_WORD;
      s_axi_rresp <= `LPDAC_RESP_OKAY;
      rd_sel_q <= LPDAC_SEL_NONE;
    end else begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid <= next_rvalid;
      if (do_read) begin
        s_axi_rdata <= view(rd_sel);
        rd_sel_q <= rd_sel;
        s_axi_rresp <= (rd_sel == LPDAC_SEL_NONE) ? `LPDAC_RESP_SLVERR
                                                  : `LPDAC_RESP_OKAY;
      end
    end
  end

  // Configuration register; only the low seven bits exist.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cfg <= `LPDAC_RST_CONFIG;
    end else if (wr_sel == LPDAC_SEL_CONFIG) begin
      cfg <= wr_word[`LPDAC_CFG_W-1:0];
    end
  end

  // Data register is forced to zero while writes are not enabled.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      data <= `LPDAC_RST_DATA;
    end else if (!cfg[`LPDAC_CFG_WE]) begin
      data <= `LPDAC_RST_DATA;
    end else if (wr_sel == LPDAC_SEL_DATA) begin
      data <= wr_word[`LPDAC_DATA_W-1:0];
    end
  end

  // Switch control register.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sw <= `LPDAC_RST_SWITCH;
    end else if (wr_sel == LPDAC_SEL_SWITCH) begin
      sw <= wr_word[`LPDAC_SW_W-1:0];
    end
  end

  // Reference buffer, common-mode mux and front-end enable registers.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      refbuf <= `LPDAC_RST_REFBUF;
      cmmux <= `LPDAC_RST_WORD;
      frontend <= `LPDAC_RST_WORD;
    end else begin
      if (wr_sel == LPDAC_SEL_REFBUF) begin
        refbuf <= wr_word[`LPDAC_REFBUF_W-1:0];
      end
      if (wr_sel == LPDAC_SEL_CMMUX) begin
        cmmux <= wr_word;
      end
      if (wr_sel == LPDAC_SEL_FRONTEND) begin
        frontend <= wr_word;
      end
    end
  end

  // Bits 6 to 1 of the configuration map one to one onto the route.
  assign cfg_route = lpdac_route_type'(cfg[`LPDAC_CFG_SRC:`LPDAC_CFG_PWD]);

  lpdac_code_mux u_code_mux (
    .route(cfg_route),
    .data_codes(data),
    .wave_codes(wave_codes),
    .codes(mux_codes),
    .node_codes(mux_nodes)
  );

  lpdac_switch_sel u_switch_sel (
    .route(cfg_route),
    .sw(sw),
    .closed(mux_closed)
  );

  // Outputs are registered so the analog side never sees decode glitches;
  // the price is one cycle from register write to pin.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dac_codes <= `LPDAC_RST_DATA;
      node_codes <= `LPDAC_RST_DATA;
      route <= lpdac_route_type'(6'(`LPDAC_RST_CONFIG >> 1));
      switch_closed <= `LPDAC_SW_OPEN;
      ref_buf_off <= `LPDAC_RST_REFBUF;
      cm_setup_en <= 1'b0;
      hs_dac_buf_en <= 1'b0;
    end else begin
      dac_codes <= mux_codes;
      node_codes <= mux_nodes;
      route <= cfg_route;
      switch_closed <= mux_closed;
      ref_buf_off <= refbuf;
      cm_setup_en <= cmmux[`LPDAC_CM_SETUP_BIT];
      hs_dac_buf_en <= frontend[`LPDAC_HS_BUF_BIT];
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_data_write;
    wr_sel == LPDAC_SEL_DATA && cfg[`LPDAC_CFG_WE] && w_strb == 4'hF;
  endsequence

  sequence s_blocked_write;
    wr_sel == LPDAC_SEL_DATA && !cfg[`LPDAC_CFG_WE];
  endsequence

  a_src_direct: assert property (
    !cfg[`LPDAC_CFG_SRC] |=> dac_codes == $past(data))
    else $error("codes not taken from data register");
  a_src_wave: assert property (
    cfg[`LPDAC_CFG_SRC] |=> dac_codes == $past(wave_codes))
    else $error("codes not taken from wave generator");
  a_pwd_open: assert property (
    cfg_route.power_down |=> switch_closed == `LPDAC_SW_OPEN)
    else $error("switch closed while powered down");
  a_diag_pattern: assert property (
    !cfg_route.power_down && !sw.override && cfg_route.diag_mode
    |=> switch_closed == `LPDAC_SW_DIAG)
    else $error("wrong diagnostic switch pattern");
  a_normal_pattern: assert property (
    !cfg_route.power_down && !sw.override && !cfg_route.diag_mode
    |=> switch_closed == `LPDAC_SW_NORMAL)
    else $error("wrong normal switch pattern");
  a_switch_override: assert property (
    !cfg_route.power_down && sw.override
    |=> switch_closed == $past(sw.closed))
    else $error("override bits not applied");
  a_data_layout: assert property (
    s_data_write |=> data.bias == $past(w_data[11:0])
    && data.zero == $past(w_data[17:12]))
    else $error("data fields misplaced");
  a_write_gated: assert property (
    s_blocked_write |=> (data == `LPDAC_RST_DATA) [*2])
    else $error("data written while writes disabled");
  a_bias_node: assert property (
    cfg_route.bias_from_6b
    |=> node_codes.bias == {$past(mux_codes.zero), 6'h00})
    else $error("bias node not fed by 6-bit output");
  a_zero_node: assert property (
    !cfg_route.zero_from_12b
    |=> node_codes.zero == $past(mux_codes.zero))
    else $error("zero node not fed by 6-bit output");
  a_ref_select: assert property (
    $rose(cfg_route.ref_supply) |=> route.ref_supply)
    else $error("reference select not passed out");
  a_reserved_zero: assert property (
    s_axi_rvalid && rd_sel_q == LPDAC_SEL_CONFIG
    |-> s_axi_rdata[31:7] == 25'h0)
    else $error("reserved config bits not zero");
  a_write_answer: assert property (
    aw_hold && w_hold && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write response missing");

endmodule : lpdac_top

`default_nettype wire

/* File: verification/lpdac_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "lpdac_cfg.svh"

// Compares a design value with its expectation and counts the outcome.
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] t=%0t %s", $time, m); end end

module tb;
  import lpdac_pkg::*;

  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [15:0] awaddr = 16'h0000;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [15:0] araddr = 16'h0000;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  lpdac_codes_type wave_codes = 18'h00000;
  lpdac_codes_type dac_codes;
  lpdac_codes_type node_codes;
  lpdac_route_type route;
  logic [4:0] switch_closed;
  logic [1:0] ref_buf_off;
  logic cm_setup_en;
  logic hs_dac_buf_en;
  int errors = 0;
  int comparisons = 0;

  lpdac_top dut (.clk_sys(clk_sys), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .wave_codes(wave_codes), .dac_codes(dac_codes),
    .node_codes(node_codes), .route(route), .switch_closed(switch_closed),
    .ref_buf_off(ref_buf_off), .cm_setup_en(cm_setup_en),
    .hs_dac_buf_en(hs_dac_buf_en));

  // Readies are registered, so the level seen at the falling edge is the
  // one the next rising edge samples; this keeps the handshake race free.
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [1:0] r);
    bit aw_t, w_t, aw_d, w_d, b_t;
    aw_d = 1'b0;
    w_d = 1'b0;
    b_t = 1'b0;
    @(posedge clk_sys);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(negedge clk_sys);
      aw_t = !aw_d && (awready === 1'b1);
      w_t = !w_d && (wready === 1'b1);
      @(posedge clk_sys);
      if (aw_t) begin
        awvalid <= 1'b0;
        aw_d = 1'b1;
      end
      if (w_t) begin
        wvalid <= 1'b0;
        w_d = 1'b1;
      end
    end
    while (!b_t) begin
      @(negedge clk_sys);
      b_t = (bvalid === 1'b1);
      r = bresp;
      @(posedge clk_sys);
    end
    bready <= 1'b0;
  endtask : wr

  // Full-word write whose response must be OKAY.
  task automatic w(input logic [15:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, 4'hF, r);
    `CHK(r, `LPDAC_RESP_OKAY, "write response")
  endtask : w

  task automatic rd(input logic [15:0] a, output logic [31:0] d,
    output logic [1:0] r);
    bit t;
    t = 1'b0;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!t) begin
      @(negedge clk_sys);
      t = (arready === 1'b1);
      @(posedge clk_sys);
    end
    arvalid <= 1'b0;
    t = 1'b0;
    while (!t) begin
      @(negedge clk_sys);
      t = (rvalid === 1'b1);
      d = rdata;
      r = rresp;
      @(posedge clk_sys);
    end
    rready <= 1'b0;
  endtask : rd

  task automatic rc(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK(r, `LPDAC_RESP_OKAY, "read response")
    `CHK(d, e, "read data")
  endtask : rc

  // Outputs follow a register update one cycle later; three is a margin.
  task automatic settle;
    repeat (3) @(negedge clk_sys);
  endtask : settle

  task automatic t_reset;
    rc(`LPDAC_OFS_CONFIG, 32'h00000002);
    rc(`LPDAC_OFS_DATA, 32'h00000000);
    rc(`LPDAC_OFS_SWITCH, 32'h00000000);
    rc(`LPDAC_OFS_REFBUF, 32'h00000000);
    rc(`LPDAC_OFS_CMMUX, 32'h00000000);
    settle;
    `CHK(route, 6'h01, "route at reset")
    `CHK(switch_closed, 5'h00, "switches at reset")
    `CHK(dac_codes, 18'h00000, "codes at reset")
    $display("test reset done");
  endtask : t_reset

  task automatic t_gate;
    w(`LPDAC_OFS_DATA, 32'h0003F123);
    rc(`LPDAC_OFS_DATA, 32'h00000000);
    w(`LPDAC_OFS_CONFIG, 32'h00000001);
    w(`LPDAC_OFS_DATA, 32'hFFFFF123);
    rc(`LPDAC_OFS_DATA, 32'h0003F123);
    settle;
    `CHK(dac_codes.zero, 6'h3F, "zero code field")
    `CHK(dac_codes.bias, 12'h123, "bias code field")
    `CHK(node_codes, 18'h3F123, "unswapped nodes")
    w(`LPDAC_OFS_CONFIG, 32'h00000000);
    rc(`LPDAC_OFS_DATA, 32'h00000000);
    $display("test gate done");
  endtask : t_gate

  task automatic t_source;
    w(`LPDAC_OFS_CONFIG, 32'h00000001);
    w(`LPDAC_OFS_DATA, 32'h0002A555);
    wave_codes <= 18'h15A5A;
    w(`LPDAC_OFS_CONFIG, 32'h00000041);
    settle;
    `CHK(dac_codes, 18'h15A5A, "wave source")
    w(`LPDAC_OFS_CONFIG, 32'h00000001);
    settle;
    `CHK(dac_codes, 18'h2A555, "data source")
    $display("test source done");
  endtask : t_source

  task automatic t_switch;
    logic [1:0] r;
    settle;
    `CHK(switch_closed, 5'h0C, "normal pattern")
    w(`LPDAC_OFS_CONFIG, 32'h00000021);
    settle;
    `CHK(switch_closed, 5'h11, "diagnostic pattern")
    wr(`LPDAC_OFS_SWITCH, 32'h0000002A, 4'h1, r);
    `CHK(r, `LPDAC_RESP_OKAY, "partial write response")
    settle;
    `CHK(switch_closed, 5'h0A, "override pattern")
    w(`LPDAC_OFS_CONFIG, 32'h00000023);
    settle;
    `CHK(switch_closed, 5'h00, "power-down opens all")
    w(`LPDAC_OFS_SWITCH, 32'h00000000);
    settle;
    `CHK(switch_closed, 5'h00, "power-down, no override")
    $display("test switch done");
  endtask : t_switch

  task automatic t_mux;
    logic [31:0] d;
    logic [1:0] r;
    w(`LPDAC_OFS_CONFIG, 32'h00000019);
    w(`LPDAC_OFS_DATA, 32'h0002A555);
    settle;
    `CHK(route, 6'h0C, "mux route bits")
    `CHK(node_codes.bias, 12'hA80, "bias node from 6-bit")
    `CHK(node_codes.zero, 6'h15, "zero node from 12-bit")
    // Loading trim: a 12-bit code below 64 times the 6-bit code drops by one.
    rd(`LPDAC_OFS_DATA, d, r);
    if (d[11:0] < {d[17:12], 6'h00}) begin
      w(`LPDAC_OFS_DATA, {d[31:12], d[11:0] - 12'h001});
    end
    rc(`LPDAC_OFS_DATA, 32'h0002A554);
    w(`LPDAC_OFS_CONFIG, 32'h00000005);
    settle;
    `CHK(route, 6'h02, "supply reference")
    $display("test mux done");
  endtask : t_mux

  task automatic t_misc;
    logic [31:0] d;
    logic [1:0] r;
    w(`LPDAC_OFS_CONFIG, 32'hFFFFFFFF);
    rc(`LPDAC_OFS_CONFIG, 32'h0000007F);
    settle;
    `CHK(route, 6'h3F, "all route bits")
    // An unmapped place must refuse both ways and change nothing.
    wr(16'h3000, 32'hFFFFFFFF, 4'hF, r);
    `CHK(r, `LPDAC_RESP_SLVERR, "unmapped write")
    rd(16'h3000, d, r);
    `CHK(r, `LPDAC_RESP_SLVERR, "unmapped read")
    `CHK(d, 32'h00000000, "unmapped data")
    w(`LPDAC_OFS_REFBUF, 32'hFFFFFFFF);
    w(`LPDAC_OFS_CMMUX, 32'h00000008);
    w(`LPDAC_OFS_FRONTEND, 32'h00200000);
    rc(`LPDAC_OFS_FRONTEND, 32'h00200000);
    settle;
    `CHK(ref_buf_off, 2'h3, "reference buffer off")
    `CHK(cm_setup_en, 1'b1, "common-mode setup")
    `CHK(hs_dac_buf_en, 1'b1, "fast buffer enable")
    $display("test misc done");
  endtask : t_misc

  task automatic test_done;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  // Free-running system clock at 200 MHz.
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  // The whole run needs well under a thousand cycles; this is a wide margin.
  initial begin
    #50000;
    errors++;
    test_done;
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset;
    t_gate;
    t_source;
    t_switch;
    t_mux;
    t_misc;
    test_done;
  end
endmodule : tb

`default_nettype wire
